// >>> verilog/apso_top.sv
// Actuator pairing sequencer, indicator driver and serial status encoder
//
// Contract
// R1: At power-up with actuator present, read its code and start auto pairing.
// R2: Skip storing the code when the actuator is already the paired one.
// R3: Auto pairing finishes after 5 s, then waits for restart.
// R4: At most 3 auto pairings; then only wired pairing on unlimited variant.
// R5: Pairable variant accepts at most two new blank transponders in lifetime.
// R6: Wired setup enters ready-for-programming at power-up, fast blinking.
// R7: Wired pairing stores actuator 5 s after it is detected within 2 mm.
// R8: Slow blink once paired and waiting restart; fast blink while pairing.
// R9: Operator keeps exactly one actuator aligned in range throughout pairing.
// R10: Status output is a pulse train encoding the whole chain status.
// R11: Idle high, 150 ms low start pulse, zero bit rises mid-slot.
// R12: One bit falls at the center of its 150 ms slot.
// R13: At least 5000 ms high between characters; 150 ms high before repeat.
// R14: Leaving range before completion restarts the 5 s timer, no store.
// R15: Exceeded auto pairing count gives failure state, red, six blinks.
`timescale 1ns/1ns
module apso_top (
   input  wire logic                      mclk,
   input  wire logic                      rst_b,
   input  wire logic                      clk_en,
   input  wire logic                      ms_tick,
   input  wire apso_pkg::apso_act_t       act,
   input  wire logic                      wired_cfg,
   input  wire logic                      unlimited_variant,
   input  wire logic                      pairable_variant,
   input  wire logic                      restart,
   input  wire logic [apso_pkg::ID_W-1:0] nv_paired_id,
   input  wire logic [1:0]                nv_auto_count,
   input  wire logic [1:0]                nv_blank_count,
   input  wire logic [apso_pkg::STATUS_BITS-1:0] chain_status,
   input  wire logic                      retransmit,
   output logic                           nv_store,
   output logic [apso_pkg::ID_W-1:0]      nv_store_id,
   output logic                           nv_auto_inc,
   output logic                           nv_blank_inc,
   output logic                           paired,
   output logic                           led_green,
   output logic                           led_red,
   output logic                           pair_fail,
   output logic                           status_out
);
   localparam logic [12:0] PAIR_MS = 13'(apso_pkg::PAIR_HOLD_MS);
   localparam logic [12:0] HALF_MS = 13'(apso_pkg::HALF_SLOT_MS);
   localparam logic [12:0] GAP_MS  = 13'(apso_pkg::INTERCHAR_MS);
   localparam logic [12:0] RETX_MS = 13'(apso_pkg::RETX_MS);
   localparam logic [12:0] SLOT_MS = 13'(apso_pkg::SLOT_MS);

   // Millisecond counter compare used by both machines
   function automatic logic reached(input logic [12:0] cnt,
                                    input logic [12:0] lim);
      reached = (cnt >= lim - 13'h0001);
   endfunction

   // ---------------- Pairing sequencer ----------------
   apso_pkg::apso_pstate_t p_reg, p_next;
   logic [12:0]            pt_reg, pt_next;
   logic                   st_reg, st_next;
   logic [apso_pkg::ID_W-1:0] id_reg, id_next;
   logic                   au_reg, au_next;
   logic                   bl_reg, bl_next;
   logic                   dn_reg, dn_next;
   logic                   blank_bad;

   // Blank refusal is checked at power-up on the auto path and again on auto or wired completion
   assign blank_bad = act.blank && (!pairable_variant ||
                      32'(nv_blank_count) >= apso_pkg::MAX_BLANK);

   always_comb begin
      p_next  = p_reg;
      pt_next = pt_reg;
      st_next = 1'b0;
      id_next = id_reg;
      au_next = 1'b0;
      bl_next = 1'b0;
      dn_next = dn_reg;
      unique case (p_reg)
         apso_pkg::APSO_P_BOOT: begin
            pt_next = 13'h0000;
            if (wired_cfg && unlimited_variant)
               p_next = apso_pkg::APSO_P_WIRED; // R6
            else if (!act.present)
               p_next = apso_pkg::APSO_P_RUN;
            else if (act.code == nv_paired_id) begin
               p_next  = apso_pkg::APSO_P_DONE; // R2
               dn_next = 1'b1;
            end else if (32'(nv_auto_count) >= apso_pkg::MAX_AUTO_PAIR)
               p_next = apso_pkg::APSO_P_FAIL; // R4 R15
            else if (blank_bad)
               p_next = apso_pkg::APSO_P_FAIL; // R5
            else begin
               p_next  = apso_pkg::APSO_P_AUTO; // R1
               id_next = act.code;
            end
         end
         apso_pkg::APSO_P_AUTO, apso_pkg::APSO_P_WIRED: begin
            if (!act.in_range || (p_reg == apso_pkg::APSO_P_AUTO &&
                                  act.code != id_reg))
               pt_next = 13'h0000; // R14 R9
            else if (ms_tick) begin
               if (reached(pt_reg, PAIR_MS) && blank_bad) begin
                  p_next  = apso_pkg::APSO_P_FAIL; // R5
               end else if (reached(pt_reg, PAIR_MS)) begin // R3 R7
                  p_next  = apso_pkg::APSO_P_DONE;
                  // An actuator already on file is not written again
                  st_next = (act.code != nv_paired_id); // R2
                  au_next = (p_reg == apso_pkg::APSO_P_AUTO) && st_next; // R4
                  bl_next = act.blank && st_next; // R5
                  id_next = act.code;
                  dn_next = 1'b1;
               end else
                  pt_next = pt_reg + 13'h0001;
            end
         end
         apso_pkg::APSO_P_DONE: begin
            if (restart)
               p_next = apso_pkg::APSO_P_RUN;
         end
         apso_pkg::APSO_P_FAIL: ;
         apso_pkg::APSO_P_RUN: ;
         default: p_next = apso_pkg::APSO_P_BOOT;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         p_reg  <= apso_pkg::APSO_P_BOOT;
         pt_reg <= 13'h0000;
         st_reg <= 1'b0;
         id_reg <= apso_pkg::ID_RST;
         au_reg <= 1'b0;
         bl_reg <= 1'b0;
         dn_reg <= 1'b0;
      end else if (clk_en) begin
         p_reg  <= p_next;
         pt_reg <= pt_next;
         st_reg <= st_next;
         id_reg <= id_next;
         au_reg <= au_next;
         bl_reg <= bl_next;
         dn_reg <= dn_next;
      end
   end

   assign nv_store     = st_reg;
   assign nv_store_id  = id_reg;
   assign nv_auto_inc  = au_reg;
   assign nv_blank_inc = bl_reg;
   assign paired       = dn_reg;
   assign pair_fail    = (p_reg == apso_pkg::APSO_P_FAIL);

   // ---------------- Indicator ----------------
   // Free-running blink phase; six red flashes then a pause, repeated
   logic [11:0] bt_reg, bt_next;
   logic        bp_reg, bp_next;
   logic [3:0]  fc_reg, fc_next;
   logic [11:0] lim;

   always_comb begin
      bt_next = bt_reg;
      bp_next = bp_reg;
      fc_next = fc_reg;
      unique case (p_reg)
         apso_pkg::APSO_P_DONE: lim = 12'(apso_pkg::SLOW_BLINK_MS);
         apso_pkg::APSO_P_FAIL:
            lim = (fc_reg == 4'(2 * apso_pkg::FAIL_BLINKS)) ?
                  12'(apso_pkg::FAIL_PAUSE_MS) :
                  12'(apso_pkg::FAIL_BLINK_MS);
         default: lim = 12'(apso_pkg::FAST_BLINK_MS);
      endcase
      if (ms_tick) begin
         if (bt_reg >= lim - 12'h001) begin
            bt_next = 12'h000;
            bp_next = ~bp_reg;
            fc_next = (fc_reg == 4'(2 * apso_pkg::FAIL_BLINKS)) ?
                      4'h0 : fc_reg + 4'h1;
         end else
            bt_next = bt_reg + 12'h001;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bt_reg <= 12'h000;
         bp_reg <= 1'b0;
         fc_reg <= 4'h0;
      end else if (clk_en) begin
         bt_reg <= bt_next;
         bp_reg <= bp_next;
         fc_reg <= fc_next;
      end
   end

   always_comb begin
      led_green = 1'b0;
      led_red   = 1'b0;
      unique case (p_reg)
         apso_pkg::APSO_P_AUTO, apso_pkg::APSO_P_WIRED,
         apso_pkg::APSO_P_DONE: led_green = bp_reg; // R8 R6
         apso_pkg::APSO_P_FAIL:
            led_red = bp_reg &&
                      fc_reg != 4'(2 * apso_pkg::FAIL_BLINKS); // R15
         apso_pkg::APSO_P_RUN:  led_green = 1'b1;
         default: ;
      endcase
   end

   // ---------------- Status encoder ----------------
   // Each bit slot: first half sets the pre-level, mid-slot edge gives value
   apso_pkg::apso_sstate_t s_reg, s_next;
   logic [12:0] sc_reg, sc_next;
   logic [3:0]  bi_reg, bi_next;
   logic [apso_pkg::STATUS_BITS-1:0] sh_reg, sh_next;
   logic        so_reg, so_next;

   always_comb begin
      s_next  = s_reg;
      sc_next = sc_reg;
      bi_next = bi_reg;
      sh_next = sh_reg;
      so_next = so_reg;
      if (ms_tick) sc_next = sc_reg + 13'h0001;
      unique case (s_reg)
         apso_pkg::APSO_S_IDLE: begin
            so_next = 1'b1; // R11
            s_next  = apso_pkg::APSO_S_START;
            sc_next = 13'h0000;
            sh_next = chain_status; // R10
            bi_next = 4'h0;
            so_next = 1'b0;
         end
         apso_pkg::APSO_S_START:
            if (ms_tick && reached(sc_reg, SLOT_MS)) begin // R11
               s_next  = apso_pkg::APSO_S_BIT;
               sc_next = 13'h0000;
               so_next = sh_reg[0]; // Pre-level is the bit value
            end
         apso_pkg::APSO_S_BIT:
            if (ms_tick && reached(sc_reg, HALF_MS) &&
                sc_reg < HALF_MS) begin
               so_next = ~sh_reg[0]; // R11 R12
            end else if (ms_tick && reached(sc_reg, SLOT_MS)) begin
               sc_next = 13'h0000;
               sh_next = sh_reg >> 1;
               bi_next = bi_reg + 4'h1;
               if (bi_reg == 4'(apso_pkg::STATUS_BITS - 1)) begin
                  so_next = 1'b1;
                  s_next  = retransmit ? apso_pkg::APSO_S_RETX
                                       : apso_pkg::APSO_S_GAP;
               end else
                  so_next = sh_reg[1];
            end
         apso_pkg::APSO_S_RETX:
            if (ms_tick && reached(sc_reg, RETX_MS)) // R13
               s_next = apso_pkg::APSO_S_IDLE;
         apso_pkg::APSO_S_GAP:
            if (ms_tick && reached(sc_reg, GAP_MS)) // R13
               s_next = apso_pkg::APSO_S_IDLE;
         default: s_next = apso_pkg::APSO_S_GAP;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         s_reg  <= apso_pkg::APSO_S_GAP;
         sc_reg <= 13'h0000;
         bi_reg <= 4'h0;
         sh_reg <= '0;
         so_reg <= 1'b1;
      end else if (clk_en) begin
         s_reg  <= s_next;
         sc_reg <= sc_next;
         bi_reg <= bi_next;
         sh_reg <= sh_next;
         so_reg <= so_next;
      end
   end

   assign status_out = so_reg;
endmodule

// >>> verilog/apso_pkg.sv
// Shared constants and types for the actuator pairing and status output block
package apso_pkg;
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
   localparam int unsigned PAIR_HOLD_MS  = 5000;
   localparam int unsigned SLOT_MS       = 150;
   localparam int unsigned INTERCHAR_MS  = 5000;
   localparam int unsigned RETX_MS       = 150;
   localparam int unsigned HALF_SLOT_MS  = SLOT_MS / 2;
   localparam int unsigned FAST_BLINK_MS = 100;
   localparam int unsigned SLOW_BLINK_MS = 500;
   localparam int unsigned FAIL_BLINK_MS = 250;
   localparam int unsigned FAIL_PAUSE_MS = 2000;
   localparam int unsigned MAX_AUTO_PAIR = 3;
   localparam int unsigned MAX_BLANK     = 2;
   localparam int unsigned FAIL_BLINKS   = 6;
   localparam int unsigned STATUS_BITS   = 8;
   localparam int unsigned ID_W          = 32;
   localparam logic [ID_W-1:0] ID_RST    = 32'h0000_0000;

   typedef enum logic [5:0] {
      APSO_P_BOOT   = 6'h01,
      APSO_P_AUTO   = 6'h02,
      APSO_P_WIRED  = 6'h04,
      APSO_P_DONE   = 6'h08,
      APSO_P_FAIL   = 6'h10,
      APSO_P_RUN    = 6'h20
   } apso_pstate_t;

   typedef enum logic [4:0] {
      APSO_S_IDLE  = 5'h01,
      APSO_S_START = 5'h02,
      APSO_S_BIT   = 5'h04,
      APSO_S_RETX  = 5'h08,
      APSO_S_GAP   = 5'h10
   } apso_sstate_t;

   typedef struct packed {
      logic            present;
      logic            in_range;
      logic [ID_W-1:0] code;
      logic            blank;
   } apso_act_t;

   typedef struct packed {
      logic            fast_blink;
      logic            slow_blink;
      logic            red;
      logic            red_on;
   } apso_led_t;
endpackage

// >>> dv/apso_checker.sv
// Port assertions for the pairing sequencer and red indicator
`timescale 1ns/1ns
module apso_checker (
   input wire logic                      mclk,
   input wire logic                      rst_b,
   input wire apso_pkg::apso_act_t       act,
   input wire logic [apso_pkg::ID_W-1:0] nv_paired_id,
   input wire logic [1:0]                nv_auto_count,
   input wire logic [1:0]                nv_blank_count,
   input wire logic                      pairable_variant,
   input wire logic                      nv_store,
   input wire logic [apso_pkg::ID_W-1:0] nv_store_id,
   input wire logic                      nv_auto_inc,
   input wire logic                      nv_blank_inc,
   input wire logic                      paired,
   input wire logic                      pair_fail,
   input wire logic                      led_red
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_store_sets_paired: assert property (nv_store |=> paired)
      else $error("paired not set after store");
   a_store_one_cycle: assert property (nv_store |=> !nv_store)
      else $error("store pulse longer than one cycle");
   a_skip_same_code:
      assert property (nv_store |-> nv_store_id != nv_paired_id)
      else $error("stored the already paired code");
   a_auto_count_cap:
      assert property (nv_auto_inc |-> nv_store &&
         32'(nv_auto_count) < apso_pkg::MAX_AUTO_PAIR)
      else $error("auto pairing beyond limit");
   a_blank_cap:
      assert property (nv_blank_inc |-> nv_store && pairable_variant &&
         32'(nv_blank_count) < apso_pkg::MAX_BLANK)
      else $error("blank accepted beyond limit");
   a_range_lost: assert property (!act.in_range [*3] |=> !nv_store)
      else $error("store while out of range");
   a_fail_no_store: assert property (pair_fail |-> !nv_store)
      else $error("store in failure state");
   a_red_only_fail: assert property (!pair_fail |-> !led_red)
      else $error("red lit outside failure");
endmodule
bind apso_top apso_checker u_apso_checker (.mclk, .rst_b, .act,
   .nv_paired_id, .nv_auto_count, .nv_blank_count, .pairable_variant,
   .nv_store, .nv_store_id, .nv_auto_inc, .nv_blank_inc, .paired,
   .pair_fail, .led_red);

// >>> dv/apso_rx.sv
// Diagnostic receiver model that decodes the serial status line
`timescale 1ns/1ns
module apso_rx (
   input wire logic  mclk,
   input wire logic  rst_b,
   input wire logic  ms_tick,
   input wire logic  line,
   output logic [7:0]  rx_byte,
   output logic [7:0]  rx_cnt,
   output logic [15:0] rx_gap,
   output logic        rx_bad
);
   int hi, t;
   logic busy;
   logic [7:0] sh;
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hi = 0; t = 0; busy = 0; rx_cnt <= 0; rx_bad <= 0;
         rx_byte <= 0; rx_gap <= 0;
      end else if (ms_tick) begin
         if (!busy) begin
            if (line) hi = hi + 1;
            else begin
               busy = 1; t = 0; rx_gap <= 16'(hi);
            end
         end else begin
            t = t + 1;
            if (t == 75 && line) rx_bad <= 1;
            // Level late in the slot tells which way the centre edge went
            if (t > 150 && (t - 150) % 150 == 110) sh = {!line, sh[7:1]};
            if (t == 1350) begin
               // Line went high at the previous tick, so this sample counts
               busy = 0; hi = 1; rx_byte <= sh; rx_cnt <= rx_cnt + 1;
            end
         end
      end
   end
endmodule

// >>> dv/tb_actuator_pairing_status_output.sv
// Self-checking bench for the pairing sequencer and status encoder
`timescale 1ns/1ns
module tb_actuator_pairing_status_output;
   logic mclk = 0, rst_b = 0, ms_tick = 0, wired_cfg = 0, unl = 0;
   logic pairable = 0, restart = 0, retransmit = 0;
   apso_pkg::apso_act_t act = '0;
   logic [31:0] nv_paired_id = 0, nv_store_id, sid;
   logic [1:0] auto_cnt = 0, blank_cnt = 0;
   logic [7:0] chain_status = 0, rx_byte, rx_cnt;
   logic [15:0] rx_gap;
   logic nv_store, nv_auto_inc, nv_blank_inc, paired, led_green, led_red;
   logic pair_fail, status_out, rx_bad, s_auto, s_blank, g_q, r_q;
   int n_fail = 0, check_count = 0, ms_n = 0, stores = 0, g_e = 0, r_e = 0;
   int cyc = 0, t, e0, st0;
   always #10 mclk = ~mclk;
   // Millisecond timebase sped up to every other cycle to keep runs short
   always @(posedge mclk) ms_tick <= !ms_tick;
   always @(posedge mclk) begin
      cyc++;
      if (ms_tick) ms_n++;
      if (nv_store) begin
         stores++; sid = nv_store_id; s_auto = nv_auto_inc;
         s_blank = nv_blank_inc;
      end
      if (led_green !== g_q) g_e++;
      if (led_red !== r_q) r_e++;
      g_q = led_green; r_q = led_red;
      if (cyc == 90000) begin
         n_fail++; report_and_stop();
      end
   end
   apso_top u_apso_top (.mclk(mclk), .rst_b(rst_b), .clk_en(1'b1),
      .ms_tick(ms_tick), .act(act), .wired_cfg(wired_cfg),
      .unlimited_variant(unl), .pairable_variant(pairable),
      .restart(restart), .nv_paired_id(nv_paired_id),
      .nv_auto_count(auto_cnt), .nv_blank_count(blank_cnt),
      .chain_status(chain_status), .retransmit(retransmit),
      .nv_store(nv_store), .nv_store_id(nv_store_id),
      .nv_auto_inc(nv_auto_inc), .nv_blank_inc(nv_blank_inc),
      .paired(paired), .led_green(led_green), .led_red(led_red),
      .pair_fail(pair_fail), .status_out(status_out));
   apso_rx u_apso_rx (.mclk(mclk), .rst_b(rst_b), .ms_tick(ms_tick),
      .line(status_out), .rx_byte(rx_byte), .rx_cnt(rx_cnt),
      .rx_gap(rx_gap), .rx_bad(rx_bad));
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task wms(int n);
      repeat (2 * n) @(posedge mclk);
   endtask
   task rst;
      rst_b <= 0;
      repeat (3) @(posedge mclk);
      rst_b <= 1;
      st0 = stores; e0 = ms_n;
   endtask
   task wstore;
      while (stores == st0 && ms_n - e0 < 6000) @(posedge mclk);
      t = ms_n - e0;
      chk("store_time", 32'(t >= 4999 && t <= 5002), 1);
   endtask
   task wrx(int n);
      int k;
      k = 0;
      while (rx_cnt < 8'(n) && k < 16000) begin
         @(posedge mclk); k++;
      end
   endtask
   task t_auto;
      act <= '{1'b1, 1'b1, 32'h5a5a_0001, 1'b1};
      pairable <= 1; blank_cnt <= 2'h1; nv_paired_id <= 32'h1111;
      rst();
      wms(1000); t = g_e; wms(1000); t = g_e - t;
      wstore();
      chk("id", sid, 32'h5a5a_0001);
      chk("auto_inc", {s_auto, s_blank}, 2'h3);
      chk("paired", paired, 1);
      e0 = g_e; wms(1000);
      chk("blink_rate", 32'(t > g_e - e0 && g_e > e0), 1);
      restart <= 1; wms(20); e0 = g_e; wms(500); restart <= 0;
      chk("steady", 32'(g_e - e0), 0);
      nv_paired_id <= 32'h5a5a_0001;
      rst(); wms(100);
      chk("same_code", {paired, 8'(stores - st0)}, 9'h100);
   endtask
   task t_fail;
      for (int i = 0; i < 2; i++) begin
         auto_cnt <= i ? 2'h0 : 2'h3; blank_cnt <= 2'h2;
         nv_paired_id <= 32'h2222;
         rst(); e0 = r_e; wms(300);
         chk("fail", {pair_fail, paired}, 2'h2);
         chk("red_blink", 32'(r_e > e0), 1);
      end
   endtask
   task t_wired;
      wired_cfg <= 1; unl <= 1; auto_cnt <= 2'h3; act.blank <= 0;
      act.in_range <= 0; act.code <= 32'h0bad_cafe;
      rst(); e0 = g_e; wms(200);
      chk("ready", {paired, pair_fail}, 2'h0);
      chk("ready_blink", 32'(g_e > e0), 1);
      act.in_range <= 1; wms(3000); act.in_range <= 0; wms(10);
      chk("no_early", 32'(stores - st0), 0);
      act.in_range <= 1; e0 = ms_n;
      wstore();
      chk("wired_id", sid, 32'h0bad_cafe);
      wired_cfg <= 0;
   endtask
   task t_status;
      chain_status <= 8'ha5; retransmit <= 1;
      rst(); wrx(1);
      chk("char1", {rx_bad, rx_byte}, 9'h0a5);
      wms(200); retransmit <= 0; chain_status <= 8'h3c;
      wrx(2);
      chk("retx", 32'(rx_gap >= 140 && rx_gap <= 160), 1);
      chk("char2", rx_byte, 8'ha5);
      wrx(3);
      chk("gap", 32'(rx_gap >= 5000), 1);
      chk("char3", {rx_bad, rx_byte}, 9'h03c);
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      @(posedge mclk);
      t_auto(); t_fail(); t_wired(); t_status();
      report_and_stop();
   end
endmodule
